// ==== sfs_front_end.sv ====
`default_nettype none
module sfs_front_end
    import sfs_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              serialClk,
    input  wire logic              chipSelN,
    input  wire logic              dataLine0In,
    output logic                   dataLine0Out,
    output logic                   dataLine0Oe,
    output logic                   dataLine1Out,
    output logic                   dataLine1Oe,
    input  wire logic [7:0]        statusByte,
    input  wire logic [7:0]        readByte,
    output logic                   opcodeStb,
    output logic                   addrStb,
    output logic                   byteStb,
    output logic                   readReq,
    output logic                   cmdEndStb,
    output sfs_cmd_t               cmd,
    output logic [ADDR_W-1:SECTOR_LSB] sectorIdx,
    output logic [ADDR_W-1:BLOCK_LSB]  blockIdx,
    output logic [ADDR_W-1:PAGE_LSB]   pageIdx
);
    sfs_state_t s_r;
    sfs_state_t s_nxt;

    logic clkRise;
    logic clkFall;
    logic csLow;
    logic csRiseEv;
    logic csFallEv;
    logic busy;
    logic dinBit;

    // Edges count once the second stage holds the new level and the third still holds the old one.
    assign clkRise  = s_r.clkSync[1] & ~s_r.clkSync[2];
    assign clkFall  = ~s_r.clkSync[1] & s_r.clkSync[2];
    assign csLow    = ~s_r.csSync[1] & ~s_r.csSync[2];
    assign csRiseEv = s_r.csSync[1] & ~s_r.csSync[2];
    assign csFallEv = ~s_r.csSync[1] & s_r.csSync[2];
    assign busy     = statusByte[BUSY_BIT];
    assign dinBit   = s_r.dioSync[2];

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.clkSync = {s_r.clkSync[1:0], serialClk};
        s_nxt.csSync  = {s_r.csSync[1:0], chipSelN};
        s_nxt.dioSync = {s_r.dioSync[1:0], dataLine0In};
        s_nxt.opcodeStb = 1'b0;
        s_nxt.addrStb   = 1'b0;
        s_nxt.byteStb   = 1'b0;
        s_nxt.rdReq     = 1'b0;
        s_nxt.endStb    = 1'b0;
        if (csFallEv)
        begin
            s_nxt.armed = 1'b1;
        end
        if (!csLow)
        begin
            // Deselect resets framing only; internal cycles run on in the core.
            if (csRiseEv)
            begin
                s_nxt.endStb = (s_r.phase != ST_IDLE);
            end
            s_nxt.phase  = ST_IDLE;
            s_nxt.bitCnt = BITCNT_RESET;
            s_nxt.dual   = 1'b0;
            s_nxt.doOe   = 1'b0;
            s_nxt.dioOe  = 1'b0;
        end
        else
        begin
            if (s_r.phase == ST_IDLE && s_r.armed)
            begin
                s_nxt.phase = ST_OPCODE;
            end
            if (clkRise)
            begin
                s_nxt.shiftIn = {s_r.shiftIn[6:0], dinBit};
                s_nxt.bitCnt  = s_r.bitCnt + 4'h1;
                if (s_r.bitCnt == 4'h7)
                begin
                    s_nxt.bitCnt = BITCNT_RESET;
                    case (s_r.phase)
                        ST_OPCODE:
                        begin
                            s_nxt.opcode    = {s_r.shiftIn[6:0], dinBit};
                            s_nxt.opcodeStb = 1'b1;
                            s_nxt.pageCnt   = PAGECNT_RESET;
                            if (busy && {s_r.shiftIn[6:0], dinBit} != OP_READ_STATUS)
                                s_nxt.phase = ST_IGNORE;
                            else if ({s_r.shiftIn[6:0], dinBit} == OP_READ_STATUS)
                            begin
                                s_nxt.phase    = ST_RDATA;
                                s_nxt.shiftOut = statusByte;
                            end
                            else
                            begin
                                s_nxt.phase     = ST_ADDR;
                                s_nxt.addrBytes = 2'h0;
                            end
                        end
                        ST_ADDR:
                        begin
                            s_nxt.addr = {s_r.addr[ADDR_W-9:0], s_r.shiftIn[6:0], dinBit};
                            s_nxt.addrBytes = s_r.addrBytes + 2'h1;
                            if (s_r.addrBytes == 2'h2)
                            begin
                                s_nxt.addrStb = 1'b1;
                                if (s_r.opcode == OP_PAGE_PROG)
                                    s_nxt.phase = ST_WDATA;
                                else if (s_r.opcode == OP_DUAL_READ)
                                    s_nxt.phase = ST_DUMMY;
                                else
                                begin
                                    s_nxt.phase = ST_RDATA;
                                    s_nxt.rdReq = 1'b1;
                                end
                            end
                        end
                        ST_DUMMY:
                        begin
                            s_nxt.phase = ST_RDATA;
                            s_nxt.dual  = 1'b1;
                            s_nxt.rdReq = 1'b1;
                        end
                        ST_WDATA:
                        begin
                            // Bytes past a full page are dropped.
                            if (s_r.pageCnt < 9'(PAGE_BYTES))
                            begin
                                s_nxt.byteData = {s_r.shiftIn[6:0], dinBit};
                                s_nxt.byteStb  = 1'b1;
                                s_nxt.pageCnt  = s_r.pageCnt + 9'h001;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
                if (s_r.phase == ST_RDATA && s_r.dual && s_r.bitCnt == 4'h3)
                begin
                    s_nxt.bitCnt = BITCNT_RESET;
                end
            end
            if (clkFall && s_r.phase == ST_RDATA)
            begin
                s_nxt.doOe = 1'b1;
                if (s_r.dual)
                begin
                    // Line 1 carries the higher bit of each pair.
                    s_nxt.dioOe    = 1'b1;
                    s_nxt.doOut    = s_r.shiftOut[7];
                    s_nxt.dioOut   = s_r.shiftOut[6];
                    s_nxt.shiftOut = {s_r.shiftOut[5:0], 2'h0};
                end
                else
                begin
                    s_nxt.doOut    = s_r.shiftOut[7];
                    s_nxt.shiftOut = {s_r.shiftOut[6:0], 1'b0};
                end
            end
            if (s_r.rdReq)
            begin
                // The core answers for the full cmd.addr in this cycle; then step past it.
                s_nxt.shiftOut = readByte;
                s_nxt.addr     = s_r.addr + ADDR_W'(1);
            end
            else if (clkRise && s_r.phase == ST_RDATA && s_nxt.bitCnt == BITCNT_RESET
                     && s_r.bitCnt != BITCNT_RESET)
            begin
                // Fetch the next byte well before the coming falling edge.
                if (s_r.opcode == OP_READ_STATUS)
                    s_nxt.shiftOut = statusByte;
                else
                    s_nxt.rdReq = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.clkSync <= SYNC_RESET;
            s_r.csSync  <= CS_SYNC_RESET;
            s_r.phase   <= ST_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign dataLine1Out = s_r.doOut;
    assign dataLine1Oe  = s_r.doOe;
    assign dataLine0Out = s_r.dioOut;
    assign dataLine0Oe  = s_r.dioOe;
    assign opcodeStb    = s_r.opcodeStb;
    assign addrStb      = s_r.addrStb;
    assign byteStb      = s_r.byteStb;
    assign readReq      = s_r.rdReq;
    assign cmdEndStb    = s_r.endStb;
    assign cmd          = '{opcode: s_r.opcode, addr: s_r.addr, data: s_r.byteData,
                            pageCount: s_r.pageCnt};
    assign sectorIdx    = s_r.addr[ADDR_W-1:SECTOR_LSB];
    assign blockIdx     = s_r.addr[ADDR_W-1:BLOCK_LSB];
    assign pageIdx      = s_r.addr[ADDR_W-1:PAGE_LSB];

    chk_desel_float: assert property (@(posedge ref_clk) disable iff (rst)
        (s_r.csSync[2:1] == 2'b11) |=> (!dataLine1Oe && !dataLine0Oe))
        else $error("Outputs driven while deselected.");
    chk_no_arm_cmd: assert property (@(posedge ref_clk) disable iff (rst)
        !s_r.armed |-> !opcodeStb)
        else $error("Opcode taken before first select.");
    chk_dual_only: assert property (@(posedge ref_clk) disable iff (rst)
        dataLine0Oe |-> (s_r.opcode == OP_DUAL_READ))
        else $error("Data line 0 driven outside dual read.");
    chk_out_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(dataLine1Out) |-> $past(clkFall))
        else $error("Output changed away from a falling edge.");
    chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (rst)
        (opcodeStb && busy && cmd.opcode != OP_READ_STATUS) |-> s_r.phase == ST_IGNORE)
        else $error("Instruction obeyed while busy.");
    chk_page_limit: assert property (@(posedge ref_clk) disable iff (rst)
        cmd.pageCount <= 9'(PAGE_BYTES))
        else $error("Page byte count above one page.");
    chk_bit_reset: assert property (@(posedge ref_clk) disable iff (rst)
        csRiseEv |=> (s_r.bitCnt == BITCNT_RESET && s_r.phase == ST_IDLE))
        else $error("Bit counter survived deselect.");
    chk_dual_pair: assert property (@(posedge ref_clk) disable iff (rst)
        (clkFall && s_r.dual && s_r.phase == ST_RDATA && csLow) |=>
        (dataLine1Out == $past(s_r.shiftOut[7]) && dataLine0Out == $past(s_r.shiftOut[6])))
        else $error("Dual pair not placed on both lines.");
endmodule // sfs_front_end
`default_nettype wire

// ==== sfs_pkg.sv ====
`default_nettype none
package sfs_pkg;
    // Geometry of the array behind the serial front end.
    localparam int PAGE_BYTES   = 256;
    localparam int SECTOR_BYTES = 4096;
    localparam int BLOCK_BYTES  = 65536;
    localparam int ADDR_W       = 20;
    localparam int SECTOR_LSB   = 12;
    localparam int BLOCK_LSB    = 16;
    localparam int PAGE_LSB     = 8;
    localparam int BUSY_BIT     = 0;

    // Instruction codes the front end must recognise for line usage and busy gating.
    localparam logic [7:0] OP_DUAL_READ   = 8'h3B;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_PAGE_PROG   = 8'h02;

    // Synchroniser and counter reset values.
    localparam logic [2:0] SYNC_RESET = 3'h0;
    // Select stages start low, so a select held low through reset never looks like a fall.
    localparam logic [2:0] CS_SYNC_RESET = 3'h0;
    localparam logic [3:0] BITCNT_RESET = 4'h0;
    localparam logic [8:0] PAGECNT_RESET = 9'h000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_DUMMY,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } sfs_phase_t;

    typedef struct packed {
        logic [2:0] clkSync;
        logic [2:0] csSync;
        logic [2:0] dioSync;
        logic       armed;
        sfs_phase_t phase;
        logic [3:0] bitCnt;
        logic [1:0] addrBytes;
        logic [7:0] shiftIn;
        logic [7:0] opcode;
        logic [ADDR_W-1:0] addr;
        logic [7:0] shiftOut;
        logic [8:0] pageCnt;
        logic       dual;
        logic       doOut;
        logic       doOe;
        logic       dioOut;
        logic       dioOe;
        logic       opcodeStb;
        logic       addrStb;
        logic       byteStb;
        logic       rdReq;
        logic       endStb;
        logic [7:0] byteData;
    } sfs_state_t;

    typedef struct packed {
        logic [7:0]        opcode;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
        logic [8:0]        pageCount;
    } sfs_cmd_t;
endpackage : sfs_pkg
`default_nettype wire

// ==== sfs_spi_master.sv ====
`default_nettype none
module sfs_spi_master
(
    output logic      serialClk,
    output logic      chipSelN,
    output logic      dataLine0In,
    input  wire logic dataLine0Out,
    input  wire logic dataLine0Oe,
    input  wire logic dataLine1Out,
    input  wire logic dataLine1Oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic cpol = 1'b0;
    logic mDrv = 1'b1;
    // The shared line follows the device while it drives, else the master.
    assign dataLine0In = dataLine0Oe ? dataLine0Out : mDrv;
    initial
    begin
        serialClk = 1'b0;
        // Select starts low, so the first frame needs a real rise and fall first.
        chipSelN = 1'b0;
    end
    task automatic sel();
        serialClk = cpol;
        #62.5 chipSelN = 1'b0;
        #62.5;
    endtask
    task automatic desel();
        serialClk = cpol;
        #62.5 chipSelN = 1'b1;
        mDrv = ~mDrv;
        #125;
    endtask
    task automatic xbit(input logic b, output logic [1:0] got);
        serialClk = 1'b0;
        mDrv = b;
        #62.5 serialClk = 1'b1;
        got = {dataLine1Oe ? dataLine1Out : 1'bz, dataLine0In};
        #62.5;
    endtask
    // Dual bytes release the shared line; its level then flips each bit.
    task automatic xbyte(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
        logic [1:0] g;
        rx = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++)
        begin
            xbit(dual ? ~mDrv : tx[7-i], g);
            rx = dual ? {rx[5:0], g} : {rx[6:0], g[1]};
        end
    endtask
endmodule // sfs_spi_master
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top
    import sfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic serialClk, chipSelN, dataLine0In, dataLine0Out, dataLine0Oe;
    logic dataLine1Out, dataLine1Oe, opcodeStb, addrStb, byteStb, readReq, cmdEndStb;
    logic [7:0] statusByte = 8'h00;
    logic [7:0] readByte;
    logic [ADDR_W-1:0] addrSeen;
    logic [23:0] idxSeen;
    logic [7:0] rx;
    logic [1:0] g;
    sfs_cmd_t cmd;
    logic [ADDR_W-1:SECTOR_LSB] sectorIdx;
    logic [ADDR_W-1:BLOCK_LSB]  blockIdx;
    logic [ADDR_W-1:PAGE_LSB]   pageIdx;
    int badCount = 0;
    int checkCount = 0;
    int nStb[5] = '{0, 0, 0, 0, 0};
    int base[5];
    logic oe0Seen, oe1Seen;

    always #4 ref_clk = ~ref_clk;

    // Array model: even addresses hold 3Ch, odd addresses hold C3h.
    assign readByte = cmd.addr[0] ? 8'hC3 : 8'h3C;

    sfs_front_end sfs_front_end_inst (.ref_clk(ref_clk), .rst(rst), .serialClk(serialClk),
        .chipSelN(chipSelN), .dataLine0In(dataLine0In), .dataLine0Out(dataLine0Out),
        .dataLine0Oe(dataLine0Oe), .dataLine1Out(dataLine1Out), .dataLine1Oe(dataLine1Oe),
        .statusByte(statusByte), .readByte(readByte), .opcodeStb(opcodeStb),
        .addrStb(addrStb), .byteStb(byteStb), .readReq(readReq), .cmdEndStb(cmdEndStb),
        .cmd(cmd), .sectorIdx(sectorIdx), .blockIdx(blockIdx), .pageIdx(pageIdx));
    sfs_spi_master sfs_spi_master_inst (.serialClk(serialClk), .chipSelN(chipSelN),
        .dataLine0In(dataLine0In), .dataLine0Out(dataLine0Out), .dataLine0Oe(dataLine0Oe),
        .dataLine1Out(dataLine1Out), .dataLine1Oe(dataLine1Oe));

    always @(negedge ref_clk)
    begin
        nStb[0] += (opcodeStb === 1'b1);
        nStb[1] += (addrStb === 1'b1);
        nStb[2] += (byteStb === 1'b1);
        nStb[3] += (readReq === 1'b1);
        nStb[4] += (cmdEndStb === 1'b1);
        if (addrStb === 1'b1)
        begin
            addrSeen = cmd.addr;
            idxSeen  = {sectorIdx, blockIdx, pageIdx};
        end
        if (dataLine0Oe === 1'b1) oe0Seen = 1'b1;
        if (dataLine1Oe === 1'b1) oe1Seen = 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic closeOut();
        $display("checks=%0d mismatches=%0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic prep(input logic [7:0] st, input logic pol);
        @(posedge ref_clk);
        #1 statusByte = st;
        sfs_spi_master_inst.cpol = pol;
        base = nStb;
        oe0Seen = 1'b0;
        oe1Seen = 1'b0;
    endtask
    task automatic tx4(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                       input logic [7:0] d);
        sfs_spi_master_inst.xbyte(a, 1'b0, rx);
        sfs_spi_master_inst.xbyte(b, 1'b0, rx);
        sfs_spi_master_inst.xbyte(c, 1'b0, rx);
        sfs_spi_master_inst.xbyte(d, 1'b0, rx);
    endtask

    task automatic t_unarmed();
        prep(8'h00, 1'b0);
        sfs_spi_master_inst.xbyte(OP_READ_STATUS, 1'b0, rx);
        sfs_spi_master_inst.desel();
        check(nStb[0] - base[0], 0);
    endtask
    task automatic t_status();
        prep(8'hA5, 1'b0);
        sfs_spi_master_inst.sel();
        sfs_spi_master_inst.xbyte(OP_READ_STATUS, 1'b0, rx);
        sfs_spi_master_inst.xbyte(8'h00, 1'b0, rx);
        check(rx, 8'hA5);
        sfs_spi_master_inst.desel();
        check({oe1Seen, oe0Seen}, 2'b10);
        check({dataLine1Oe, dataLine0Oe}, 2'b00);
        check(nStb[4] - base[4], 1);
    endtask
    task automatic t_dual();
        prep(8'h00, 1'b1);
        sfs_spi_master_inst.sel();
        tx4(OP_DUAL_READ, 8'h0F, 8'h12, 8'h34);
        sfs_spi_master_inst.xbyte(8'h00, 1'b0, rx);
        sfs_spi_master_inst.xbyte(8'h00, 1'b1, rx);
        check(rx, 8'h3C);
        sfs_spi_master_inst.xbyte(8'h00, 1'b1, rx);
        check(rx, 8'hC3);
        sfs_spi_master_inst.desel();
        check(addrSeen, 20'hF1234);
        check(idxSeen, {8'hF1, 4'hF, 12'hF12});
        check(nStb[1] - base[1], 1);
        check(nStb[3] - base[3], 3);
        check(oe0Seen, 1'b1);
        check({dataLine1Oe, dataLine0Oe}, 2'b00);
    endtask
    task automatic t_prog();
        prep(8'h00, 1'b0);
        sfs_spi_master_inst.sel();
        tx4(OP_PAGE_PROG, 8'h00, 8'h01, 8'h00);
        for (int i = 0; i < 257; i++)
            sfs_spi_master_inst.xbyte(i[7:0], 1'b0, rx);
        sfs_spi_master_inst.desel();
        check(nStb[2] - base[2], 256);
        check({cmd.opcode, cmd.data}, {OP_PAGE_PROG, 8'hFF});
        check(cmd.pageCount, 9'h100);
    endtask
    task automatic t_busy();
        prep(8'h01, 1'b0);
        sfs_spi_master_inst.sel();
        tx4(OP_PAGE_PROG, 8'h00, 8'h02, 8'h00);
        sfs_spi_master_inst.xbyte(8'hAA, 1'b0, rx);
        sfs_spi_master_inst.desel();
        check(nStb[1] - base[1], 0);
        check(nStb[2] - base[2], 0);
        sfs_spi_master_inst.sel();
        sfs_spi_master_inst.xbyte(OP_READ_STATUS, 1'b0, rx);
        sfs_spi_master_inst.xbyte(8'h00, 1'b0, rx);
        sfs_spi_master_inst.desel();
        check(rx, 8'h01);
    endtask
    task automatic t_abort();
        prep(8'h00, 1'b0);
        sfs_spi_master_inst.sel();
        for (int i = 0; i < 4; i++)
            sfs_spi_master_inst.xbit(1'b1, g);
        sfs_spi_master_inst.desel();
        sfs_spi_master_inst.xbyte(OP_READ_STATUS, 1'b0, rx);
        check(nStb[0] - base[0], 0);
        sfs_spi_master_inst.sel();
        sfs_spi_master_inst.xbyte(OP_READ_STATUS, 1'b0, rx);
        sfs_spi_master_inst.desel();
        check(nStb[0] - base[0], 1);
        check(cmd.opcode, OP_READ_STATUS);
    endtask

    initial
    begin
        // The scenarios take about 300 us; twice that means a hang.
        #600000;
        badCount++;
        closeOut();
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'b0;
        t_unarmed();
        t_status();
        t_dual();
        t_prog();
        t_busy();
        t_abort();
        closeOut();
    end
endmodule // tb_top
`default_nettype wire
